//--- gpb_pkg.sv
// Shared constants and carrier types of the pin port and direction bank.
package gpb_pkg;

   localparam int NUM_PORTS = 10;
   localparam int SEL_P6 = 6;
   localparam int SEL_P12 = 8;
   localparam int SEL_P14 = 9;

   // Direction register addresses, index 8 is port 12 and index 9 is port 14.
   localparam logic [NUM_PORTS-1:0][15:0] DIR_ADDR = {
      16'hff2e, 16'hff2c, 16'hff27, 16'hff26, 16'hff25,
      16'hff24, 16'hff23, 16'hff22, 16'hff21, 16'hff20};

   // Latch and pull-up option addresses; only ports flagged in the enables use them.
   localparam logic [NUM_PORTS-1:0][15:0] LAT_ADDR = {
      16'hff0e, 16'hff0c, 16'h0000, 16'hff06, 16'h0000,
      16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
   localparam logic [NUM_PORTS-1:0][15:0] PU_ADDR = {
      16'hff3e, 16'hff3c, 16'h0000, 16'h0000, 16'h0000,
      16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
   localparam logic [NUM_PORTS-1:0] LAT_EN = 10'h340;
   localparam logic [NUM_PORTS-1:0] PU_EN = 10'h300;
   localparam logic [NUM_PORTS-1:0] OD_EN = 10'h040;

   // Pins that exist on each port and pins that carry an optional pull-up.
   localparam logic [NUM_PORTS-1:0][7:0] PIN_MASK = {
      8'h03, 8'h1f, 8'hff, 8'h0f, 8'h0f,
      8'h0f, 8'h0f, 8'hff, 8'hff, 8'h7f};
   localparam logic [NUM_PORTS-1:0][7:0] PULLUP_MASK = {
      8'h03, 8'h01, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

   localparam logic [15:0] OUT_ONLY_LAT_ADDR = 16'hff0d;
   localparam logic [7:0] OUT_ONLY_MASK = 8'h01;
   localparam logic [7:0] OSC_PIN_MASK = 8'h1e;
   localparam logic [7:0] CLOCK_MODE_RESET = 8'h00;

   localparam logic [7:0] DIR_RESET = 8'hff;
   localparam logic [7:0] LAT_RESET = 8'h00;
   localparam logic [7:0] PU_RESET = 8'h00;
   localparam logic [7:0] BYTE_MASK = 8'hff;
   localparam logic [7:0] BIT_ZERO = 8'h01;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   typedef struct packed {
      logic [7:0] pin_out;
      logic [7:0] pin_oe;
      logic [7:0] pullup_en;
   } gpb_pins_s;

   typedef struct packed {
      logic [7:0] dir;
      logic [7:0] lat;
      logic [7:0] pu;
   } gpb_port_state_s;

   typedef struct packed {
      logic [7:0] rdata;
      logic rvalid;
      logic out_only_lat;
   } gpb_bank_state_s;

   typedef logic [NUM_PORTS-1:0][7:0] gpb_byte_bank_t;

endpackage

//--- gpb_port.sv
// One port: direction register, output latch, pull-up option and pin drive.
`timescale 1ns/10ps
module gpb_port #(
   parameter logic [7:0] PIN_MASK = 8'hff,
   parameter logic [7:0] PULLUP_MASK = 8'h00,
   parameter bit OPEN_DRAIN = 1'b0
) (
   input wire logic clock_in,
   input wire logic reset_n_in,
   input wire logic dir_wr_in,
   input wire logic lat_wr_in,
   input wire logic pu_wr_in,
   input wire logic [7:0] wr_mask_in,
   input wire logic [7:0] wr_data_in,
   input wire logic [7:0] claim_in,
   input wire logic [7:0] pin_in,
   output gpb_pkg::gpb_pins_s pins_out,
   output logic [7:0] dir_out,
   output logic [7:0] lat_rd_out,
   output logic [7:0] pu_out
);

   gpb_pkg::gpb_port_state_s st_r;
   gpb_pkg::gpb_port_state_s st_nxt;

   if ((PULLUP_MASK & ~PIN_MASK) != 8'h00)
   begin : g_bad_mask
      $error("Pull-up mask names a pin that the port does not have.");
   end

   always_comb
   begin
      st_nxt = st_r;
      if (dir_wr_in)
      begin
         st_nxt.dir = (st_r.dir & ~wr_mask_in) | (wr_data_in & wr_mask_in) | ~PIN_MASK;
      end
      if (lat_wr_in)
      begin
         st_nxt.lat = ((st_r.lat & ~wr_mask_in) | (wr_data_in & wr_mask_in)) & PIN_MASK;
      end
      if (pu_wr_in)
      begin
         st_nxt.pu = ((st_r.pu & ~wr_mask_in) | (wr_data_in & wr_mask_in)) & PULLUP_MASK;
      end
   end

   always_ff @(posedge clock_in)
   begin
      if (!reset_n_in)
      begin
         st_r.dir <= gpb_pkg::DIR_RESET;
         st_r.lat <= gpb_pkg::LAT_RESET;
         st_r.pu <= gpb_pkg::PU_RESET;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // A zero direction bit selects output; claimed pins are left to the oscillator.
   always_comb
   begin
      pins_out.pin_oe = ~st_r.dir & PIN_MASK & ~claim_in;
      if (OPEN_DRAIN)
      begin
         pins_out.pin_oe = pins_out.pin_oe & ~st_r.lat;
         pins_out.pin_out = 8'h00;
      end
      else
      begin
         pins_out.pin_out = st_r.lat & PIN_MASK;
      end
      pins_out.pullup_en = st_r.pu & st_r.dir & PULLUP_MASK & ~claim_in;
   end

   assign dir_out = st_r.dir;
   assign lat_rd_out = ((pin_in & st_r.dir) | (st_r.lat & ~st_r.dir)) & PIN_MASK;
   assign pu_out = st_r.pu;

endmodule // gpb_port

//--- gpb_bank.sv
// Pin port and direction register bank on the internal byte bus.
//
// Overview of operation
// - The open-drain port has four pins, each switchable by its direction bit.
// - Open-drain pins pull low for latch zero and float for latch one.
// - The clock-shared port has five pins, each with its own direction bit.
// - Only pin zero of the clock-shared port has a pull-up, in input mode.
// - With clock mode at reset value, the oscillator pins act as ordinary pins.
// - The output-only pin has a latch and no direction register.
// - The output-only pin is driven low during and after reset.
// - Last port pins zero and one have per-bit pull-ups in input mode.
// - Direction registers take single-bit writes as well as whole-byte writes.
// - Reset loads every direction register with all ones, input mode.
// - Direction bits without a pin read as one and never change.
// - Each direction bit sets the mode of the pin with the same index.
// - Latch reads return pin level for inputs and latch value for outputs.
// - Pull-ups never connect to output pins or to pins claimed elsewhere.
`timescale 1ns/10ps
module gpb_bank (
   input wire logic clock_in,
   input wire logic reset_n_in,
   input wire logic [15:0] bus_addr_in,
   input wire logic [7:0] bus_wdata_in,
   input wire logic bus_wr_in,
   input wire logic bus_rd_in,
   input wire logic bus_bit_in,
   input wire logic [2:0] bus_bit_sel_in,
   output logic [7:0] bus_rdata_out,
   output logic bus_rvalid_out,
   input wire logic [7:0] clock_operation_mode_reg_in,
   input wire logic [7:0] open_drain_port_latch_pin_in,
   output gpb_pkg::gpb_pins_s open_drain_port_latch_pins_out,
   input wire logic [7:0] clock_shared_port_latch_pin_in,
   output gpb_pkg::gpb_pins_s clock_shared_port_latch_pins_out,
   input wire logic [7:0] last_port_latch_pin_in,
   output gpb_pkg::gpb_pins_s last_port_latch_pins_out,
   output logic output_only_pin_out,
   output gpb_pkg::gpb_byte_bank_t direction_out
);

   gpb_pkg::gpb_bank_state_s st_r;
   gpb_pkg::gpb_bank_state_s st_nxt;

   logic [7:0] wr_mask;
   logic [7:0] wr_data;
   logic [7:0] osc_claim;
   gpb_pkg::gpb_byte_bank_t pin_bank;
   gpb_pkg::gpb_byte_bank_t lat_rd;
   gpb_pkg::gpb_byte_bank_t pu_rd;
   gpb_pkg::gpb_pins_s [gpb_pkg::NUM_PORTS-1:0] pins_bank;
   logic [gpb_pkg::NUM_PORTS-1:0] dir_hit;
   logic [gpb_pkg::NUM_PORTS-1:0] lat_hit;
   logic [gpb_pkg::NUM_PORTS-1:0] pu_hit;
   logic out_only_hit;

   // A bit operation touches one lane and carries its value in data bit zero.
   always_comb
   begin
      if (bus_bit_in)
      begin
         wr_mask = gpb_pkg::BIT_ZERO << bus_bit_sel_in;
         wr_data = {8{bus_wdata_in[0]}};
      end
      else
      begin
         wr_mask = gpb_pkg::BYTE_MASK;
         wr_data = bus_wdata_in;
      end
   end

   // Any non-reset clock mode hands pins one to four of the clock-shared port to the oscillator.
   always_comb
   begin
      if (clock_operation_mode_reg_in == gpb_pkg::CLOCK_MODE_RESET)
      begin
         osc_claim = 8'h00;
      end
      else
      begin
         osc_claim = gpb_pkg::OSC_PIN_MASK;
      end
   end

   always_comb
   begin
      pin_bank = '0;
      pin_bank[gpb_pkg::SEL_P6] = open_drain_port_latch_pin_in;
      pin_bank[gpb_pkg::SEL_P12] = clock_shared_port_latch_pin_in;
      pin_bank[gpb_pkg::SEL_P14] = last_port_latch_pin_in;
   end

   always_comb
   begin
      for (int k = 0; k < gpb_pkg::NUM_PORTS; k++)
      begin
         dir_hit[k] = (bus_addr_in == gpb_pkg::DIR_ADDR[k]);
         lat_hit[k] = gpb_pkg::LAT_EN[k] && (bus_addr_in == gpb_pkg::LAT_ADDR[k]);
         pu_hit[k] = gpb_pkg::PU_EN[k] && (bus_addr_in == gpb_pkg::PU_ADDR[k]);
      end
      out_only_hit = (bus_addr_in == gpb_pkg::OUT_ONLY_LAT_ADDR);
   end

   for (genvar g = 0; g < gpb_pkg::NUM_PORTS; g++)
   begin : g_port
      gpb_port #(
         .PIN_MASK(gpb_pkg::PIN_MASK[g]),
         .PULLUP_MASK(gpb_pkg::PULLUP_MASK[g]),
         .OPEN_DRAIN(gpb_pkg::OD_EN[g])
      ) u_port (
         .clock_in(clock_in),
         .reset_n_in(reset_n_in),
         .dir_wr_in(bus_wr_in && dir_hit[g]),
         .lat_wr_in(bus_wr_in && lat_hit[g]),
         .pu_wr_in(bus_wr_in && pu_hit[g]),
         .wr_mask_in(wr_mask),
         .wr_data_in(wr_data),
         .claim_in((g == gpb_pkg::SEL_P12) ? osc_claim : 8'h00),
         .pin_in(pin_bank[g]),
         .pins_out(pins_bank[g]),
         .dir_out(direction_out[g]),
         .lat_rd_out(lat_rd[g]),
         .pu_out(pu_rd[g])
      );
   end

   assign open_drain_port_latch_pins_out = pins_bank[gpb_pkg::SEL_P6];
   assign clock_shared_port_latch_pins_out = pins_bank[gpb_pkg::SEL_P12];
   assign last_port_latch_pins_out = pins_bank[gpb_pkg::SEL_P14];

   // Read data is registered and answered one cycle after the strobe; unmapped reads give zero.
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.rvalid = bus_rd_in;
      if (bus_wr_in && out_only_hit)
      begin
         st_nxt.out_only_lat = |((({7'h00, st_r.out_only_lat} & ~wr_mask) | (wr_data & wr_mask))
                                 & gpb_pkg::OUT_ONLY_MASK);
      end
      if (bus_rd_in)
      begin
         st_nxt.rdata = gpb_pkg::UNMAPPED_READ;
         for (int k = 0; k < gpb_pkg::NUM_PORTS; k++)
         begin
            if (dir_hit[k])
            begin
               st_nxt.rdata = direction_out[k];
            end
            if (lat_hit[k])
            begin
               st_nxt.rdata = lat_rd[k];
            end
            if (pu_hit[k])
            begin
               st_nxt.rdata = pu_rd[k];
            end
         end
         if (out_only_hit)
         begin
            st_nxt.rdata = {7'h00, st_r.out_only_lat};
         end
      end
   end

   always_ff @(posedge clock_in)
   begin
      if (!reset_n_in)
      begin
         st_r.rdata <= 8'h00;
         st_r.rvalid <= 1'b0;
         st_r.out_only_lat <= 1'b0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign bus_rdata_out = st_r.rdata;
   assign bus_rvalid_out = st_r.rvalid;
   assign output_only_pin_out = st_r.out_only_lat;

endmodule // gpb_bank

//--- gpb_bank_asserts.sv
// Concurrent checks on the ports of the pin port and direction bank.
`timescale 1ns/10ps
module gpb_bank_asserts (
   input wire logic clock_in,
   input wire logic reset_n_in,
   input wire logic [15:0] bus_addr_in,
   input wire logic [7:0] bus_wdata_in,
   input wire logic bus_wr_in,
   input wire logic bus_rd_in,
   input wire logic bus_bit_in,
   input wire logic [2:0] bus_bit_sel_in,
   input wire logic bus_rvalid_out,
   input wire logic [7:0] clock_operation_mode_reg_in,
   input wire gpb_pkg::gpb_pins_s open_drain_port_latch_pins_out,
   input wire gpb_pkg::gpb_pins_s clock_shared_port_latch_pins_out,
   input wire gpb_pkg::gpb_pins_s last_port_latch_pins_out,
   input wire logic output_only_pin_out,
   input wire gpb_pkg::gpb_byte_bank_t direction_out
);
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!reset_n_in);
   property p_rd; bus_rd_in |=> bus_rvalid_out; endproperty
   a_rd: assert property (p_rd) else $error("read not answered");
   property p_od; (open_drain_port_latch_pins_out.pin_oe & direction_out[6]
      | open_drain_port_latch_pins_out.pin_out) == 8'h00; endproperty
   a_od: assert property (p_od) else $error("open drain pin driven wrongly");
   property p_fix; (direction_out[9] | 8'h03) == 8'hff && (direction_out[6] | 8'h0f) == 8'hff
      && direction_out[0][7]; endproperty
   a_fix: assert property (p_fix) else $error("pinless direction bit not one");
   property p_rst; $rose(reset_n_in) |-> direction_out == {10{8'hff}} && !output_only_pin_out; endproperty
   a_rst: assert property (p_rst) else $error("reset state wrong");
   property p_pu; ((clock_shared_port_latch_pins_out.pullup_en & ~direction_out[8])
      | (last_port_latch_pins_out.pullup_en & ~direction_out[9])) == 8'h00; endproperty
   a_pu: assert property (p_pu) else $error("pull-up on output pin");
   property p_pum; ((clock_shared_port_latch_pins_out.pullup_en & 8'hfe)
      | (last_port_latch_pins_out.pullup_en & 8'hfc)) == 8'h00; endproperty
   a_pum: assert property (p_pum) else $error("pull-up on wrong pin");
   property p_osc; clock_shared_port_latch_pins_out.pin_oe
      == (~direction_out[8] & (clock_operation_mode_reg_in == 8'h00 ? 8'h1f : 8'h01)); endproperty
   a_osc: assert property (p_osc) else $error("clock shared drive wrong");
   property p_bit; bus_wr_in && bus_bit_in && bus_addr_in == 16'hff27
      |=> direction_out[7][$past(bus_bit_sel_in)] == $past(bus_wdata_in[0]); endproperty
   a_bit: assert property (p_bit) else $error("bit write lost");
   property p_oo; bus_wr_in && !bus_bit_in && bus_addr_in == 16'hff0d
      |=> output_only_pin_out == $past(bus_wdata_in[0]); endproperty
   a_oo: assert property (p_oo) else $error("output pin not written");
   c_rd: cover property (bus_rd_in);
   c_bit: cover property (bus_wr_in && bus_bit_in);
   c_oo: cover property (output_only_pin_out);
endmodule // gpb_bank_asserts
bind gpb_bank gpb_bank_asserts u_chk (.clock_in, .reset_n_in, .bus_addr_in, .bus_wdata_in, .bus_wr_in,
   .bus_rd_in, .bus_bit_in, .bus_bit_sel_in, .bus_rvalid_out, .clock_operation_mode_reg_in,
   .open_drain_port_latch_pins_out, .clock_shared_port_latch_pins_out, .last_port_latch_pins_out,
   .output_only_pin_out, .direction_out);

//--- testbench.sv
// Self-checking bench for the pin port and direction bank.
`timescale 1ns/10ps
module testbench;
   logic clock_in = 1'b0, reset_n_in = 1'b0, bus_wr_in = 1'b0, bus_rd_in = 1'b0, bus_bit_in = 1'b0;
   logic [15:0] bus_addr_in = 16'h0000;
   logic [7:0] bus_wdata_in = 8'h00, mode_in = 8'h00, od_in = 8'h0a, cs_in = 8'h00, lp_in = 8'h00;
   logic [2:0] bus_bit_sel_in = 3'h0;
   logic [7:0] bus_rdata_out;
   logic bus_rvalid_out, oo_out;
   gpb_pkg::gpb_pins_s od, cs, lp;
   gpb_pkg::gpb_byte_bank_t dir;
   int fail_count = 0, total_checks = 0;
   int ext_phase = 0;
   logic ext_clk_on = 1'b0;
   gpb_bank uut (.clock_in, .reset_n_in, .bus_addr_in, .bus_wdata_in, .bus_wr_in, .bus_rd_in, .bus_bit_in,
      .bus_bit_sel_in, .bus_rdata_out, .bus_rvalid_out, .clock_operation_mode_reg_in(mode_in),
      .open_drain_port_latch_pin_in(od_in), .open_drain_port_latch_pins_out(od),
      .clock_shared_port_latch_pin_in(cs_in), .clock_shared_port_latch_pins_out(cs),
      .last_port_latch_pin_in(lp_in), .last_port_latch_pins_out(lp), .output_only_pin_out(oo_out),
      .direction_out(dir));
   initial
   begin
      forever #2 clock_in = ~clock_in;
   end
   // Feeds the serial clock pin at 6.4 MHz on average: 32 level changes in every 625 clock cycles.
   always @(posedge clock_in)
   begin
      if (!ext_clk_on)
      begin
         ext_phase <= 0;
         od_in[2] <= 1'b0;
      end
      else if (ext_phase + 32 >= 625)
      begin
         ext_phase <= ext_phase + 32 - 625;
         od_in[2] <= ~od_in[2];
      end
      else
      begin
         ext_phase <= ext_phase + 32;
      end
   end
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [23:0] g, input logic [23:0] e);
      total_checks++;
      if (g !== e)
      begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic b, input logic [2:0] s);
      @(posedge clock_in);
      bus_addr_in <= a;
      bus_wdata_in <= d;
      bus_bit_in <= b;
      bus_bit_sel_in <= s;
      bus_wr_in <= 1'b1;
      @(posedge clock_in);
      bus_wr_in <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      @(posedge clock_in);
      bus_addr_in <= a;
      bus_rd_in <= 1'b1;
      @(posedge clock_in);
      bus_rd_in <= 1'b0;
      #1;
      chk({15'h0, bus_rvalid_out, bus_rdata_out}, {15'h0, 1'b1, e});
   endtask
   initial
   begin
      repeat (3000) @(posedge clock_in);
      fail_count++;
      report_and_stop;
   end
   initial
   begin
      repeat (20) @(posedge clock_in);
      reset_n_in <= 1'b1;
      #1;
      chk(od | cs | lp, 24'h0);
      chk({23'h0, oo_out}, 24'h0);
      for (int i = 0; i < gpb_pkg::NUM_PORTS; i++)
      begin
         rd(gpb_pkg::DIR_ADDR[i], 8'hff);
         wr(gpb_pkg::DIR_ADDR[i], 8'h00, 1'b0, 3'h0);
         rd(gpb_pkg::DIR_ADDR[i], ~gpb_pkg::PIN_MASK[i]);
         wr(gpb_pkg::DIR_ADDR[i], 8'h01, 1'b1, 3'h0);
         wr(gpb_pkg::DIR_ADDR[i], 8'h00, 1'b1, 3'h7);
         chk({16'h0, dir[i]}, {16'h0, (~gpb_pkg::PIN_MASK[i] | 8'h01) & ~(gpb_pkg::PIN_MASK[i] & 8'h80)});
         wr(gpb_pkg::DIR_ADDR[i], 8'hff, 1'b0, 3'h0);
      end
      wr(16'hff30, 8'h5a, 1'b0, 3'h0);
      rd(16'hff30, 8'h00);
      wr(16'hff26, 8'h00, 1'b0, 3'h0);
      chk(od, 24'h000f00);
      wr(16'hff26, 8'hfe, 1'b0, 3'h0);
      chk(od, 24'h000100);
      wr(16'hff06, 8'h01, 1'b0, 3'h0);
      chk(od, 24'h000000);
      rd(16'hff06, 8'h0b);
      @(posedge clock_in);
      ext_clk_on <= 1'b1;
      repeat (200) @(posedge clock_in);
      ext_clk_on <= 1'b0;
      #1;
      chk(od, 24'h000000);
      rd(16'hff06, 8'h0b);
      wr(16'hff3c, 8'hff, 1'b0, 3'h0);
      chk(cs, 24'h000001);
      wr(16'hff0c, 8'h15, 1'b0, 3'h0);
      wr(16'hff2c, 8'h00, 1'b0, 3'h0);
      chk(cs, 24'h151f00);
      @(posedge clock_in);
      mode_in <= 8'h01;
      cs_in <= 8'h0a;
      lp_in <= 8'h03;
      @(posedge clock_in);
      #1;
      chk(cs, 24'h150100);
      rd(16'hff0c, 8'h15);
      rd(16'hff3c, 8'h01);
      wr(16'hff3e, 8'hff, 1'b0, 3'h0);
      chk(lp, 24'h000003);
      rd(16'hff3e, 8'h03);
      wr(16'hff2e, 8'h00, 1'b1, 3'h0);
      chk(lp, 24'h000102);
      rd(16'hff0e, 8'h02);
      wr(16'hff0d, 8'h01, 1'b0, 3'h0);
      chk({23'h0, oo_out}, 24'h1);
      wr(16'hff0d, 8'h00, 1'b1, 3'h3);
      chk({23'h0, oo_out}, 24'h1);
      rd(16'hff0d, 8'h01);
      @(posedge clock_in);
      reset_n_in <= 1'b0;
      @(posedge clock_in);
      reset_n_in <= 1'b1;
      #1;
      chk({23'h0, oo_out}, 24'h0);
      chk({16'h0, dir[9]}, 24'hff);
      report_and_stop;
   end
endmodule // testbench
